// file: ssb_consts.vh
// constants of the scan, stacking and brightness configuration block
// assumes inclusion by bare name from the top design file, the checker and the testbench
`ifndef SSB_CONSTS_VH
`define SSB_CONSTS_VH

// register byte offsets, one aligned 32-bit word each
`define SSB_OFF_CTRL 8'h00
`define SSB_OFF_GAIN 8'h04
`define SSB_OFF_FINE 8'h08
`define SSB_OFF_MULT 8'h0C
`define SSB_OFF_STAT 8'h10
`define SSB_OFF_RSCL 8'h14
`define SSB_OFF_GSCL 8'h18
`define SSB_OFF_BSCL 8'h1C
`define SSB_OFF_SHFT 8'h20

// control and multiplier word fields
`define SSB_CTRL_STACK 0
`define SSB_CTRL_REV 1
`define SSB_CTRL_POS 2
`define SSB_CTRL_EN 3
`define SSB_CTRL_LINES_LO 4
`define SSB_CTRL_LINES_HI 9
`define SSB_MULT_FACT_HI 3
`define SSB_MULT_HALF 4
`define SSB_MULT_PER_LO 8
`define SSB_MULT_PER_HI 19

// reset values
`define SSB_RST_GAIN 3'h3
`define SSB_RST_FINE 8'h7F
`define SSB_RST_LINES 6'h10
`define SSB_RST_FACT 4'h4
`define SSB_RST_HALF 1'b1
`define SSB_RST_PER 12'h02D

// scan geometry
`define SSB_LINES_DEV 6'h10
`define SSB_LINES_STACK 6'h20

// gain table, current gain times one hundred
`define SSB_GAIN0 15'h0971
`define SSB_GAIN1 15'h0BF1
`define SSB_GAIN2 15'h1355
`define SSB_GAIN3 15'h21D5
`define SSB_GAIN4 15'h289A
`define SSB_GAIN5 15'h32C0
`define SSB_GAIN6 15'h3A00
`define SSB_GAIN7 15'h43AB

// link timing limits, in MHz
`define SSB_SCLK_MAX_MHZ 50
`define SSB_GRAY_MIN_MHZ 40
`define SSB_GRAY_MAX_MHZ 160
`define SSB_PCLK_MHZ 20

`endif

// file: ssb_sync.v
// two-flop synchroniser for levels arriving from outside the pclk domain
// assumes inputs are plain levels; first stage is read by the second only
`default_nettype none

module ssb_sync #(
    parameter WIDTH = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1_q;

// metastability settles in stage one before anyone looks
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stage1_q <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        stage1_q <= async_in;
        sync_out <= stage1_q;
    end
end

endmodule
`default_nettype wire

// file: ssb_top.v
// scan order, stacking and current-scaling configuration with apb registers
// assumes an apb master on pclk and a serial link clock slower than pclk / 4
//
// What this block does
// - independent or two-device stacked scanning modes
// - independent mode scans own sixteen lines alone
// - reverse makes second device scan lines descending
// - stacked: first lines 1-16, second 17-32
// - stacked: first holds A,C; second B,D
// - three-bit global gain code scales all channels
// - gain code table, default code three
// - colour current scales by (1+fine)/256 times gain
// - rising-edge serial transfer, daisy-chain pass-through
// - gray clock generated up to 160 MHz
// - gray clock multiplied from serial clock, configurable
`include "ssb_consts.vh"
`default_nettype none

module ssb_top #(
    parameter LINE_COUNT = 16,
    parameter SHIFT_WIDTH = 32
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire serial_clock,
    input wire serial_input,
    output reg serial_output,
    output reg [LINE_COUNT-1:0] line_switch,
    output reg gray_tick,
    output reg [14:0] global_current_gain,
    output reg [23:0] red_current_scale,
    output reg [23:0] green_current_scale,
    output reg [23:0] blue_current_scale
);

////////////////////////////////////////////////////////////////////////////////
// configuration registers

reg stack_size_select_q;
reg second_device_scan_reverse_q;
reg second_position_q;
reg scan_enable_q;
reg [5:0] lines_used_q;
reg [2:0] global_gain_code_q;
reg [7:0] red_fine_code_q;
reg [7:0] green_fine_code_q;
reg [7:0] blue_fine_code_q;
reg [3:0] mult_factor_q;
reg half_divider_q;
reg [11:0] line_period_q;

// scan and link state
reg [4:0] scan_pos_q;
reg [11:0] tick_cnt_q;
reg [3:0] gray_pending_q;
reg sclk_prev_q;
reg [SHIFT_WIDTH-1:0] shift_q;

wire [1:0] sync_bits;
wire sclk_s;
wire sin_s;
wire sclk_rise;

////////////////////////////////////////////////////////////////////////////////
// apb decode: zero wait states, unmapped offsets answer with an error

wire setup_phase = psel & ~penable;
wire write_en = psel & penable & pwrite;
reg addr_hit;

always @* begin
    case (paddr)
        `SSB_OFF_CTRL, `SSB_OFF_GAIN, `SSB_OFF_FINE, `SSB_OFF_MULT,
        `SSB_OFF_STAT, `SSB_OFF_RSCL, `SSB_OFF_GSCL, `SSB_OFF_BSCL,
        `SSB_OFF_SHFT: addr_hit = 1'b1;
        default: addr_hit = 1'b0;
    endcase
end

assign pready = 1'b1;
assign pslverr = psel & penable & ~addr_hit;

// software writes land on the access edge only
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stack_size_select_q <= 1'b0;
        second_device_scan_reverse_q <= 1'b0;
        second_position_q <= 1'b0;
        scan_enable_q <= 1'b0;
        lines_used_q <= `SSB_RST_LINES;
        global_gain_code_q <= `SSB_RST_GAIN;
        red_fine_code_q <= `SSB_RST_FINE;
        green_fine_code_q <= `SSB_RST_FINE;
        blue_fine_code_q <= `SSB_RST_FINE;
        mult_factor_q <= `SSB_RST_FACT;
        half_divider_q <= `SSB_RST_HALF;
        line_period_q <= `SSB_RST_PER;
    end else if (write_en) begin
        case (paddr)
            `SSB_OFF_CTRL: begin
                stack_size_select_q <= pwdata[`SSB_CTRL_STACK];
                second_device_scan_reverse_q <= pwdata[`SSB_CTRL_REV];
                second_position_q <= pwdata[`SSB_CTRL_POS];
                scan_enable_q <= pwdata[`SSB_CTRL_EN];
                lines_used_q <= pwdata[`SSB_CTRL_LINES_HI:`SSB_CTRL_LINES_LO];
            end
            `SSB_OFF_GAIN: global_gain_code_q <= pwdata[2:0];
            `SSB_OFF_FINE: begin
                red_fine_code_q <= pwdata[7:0];
                green_fine_code_q <= pwdata[15:8];
                blue_fine_code_q <= pwdata[23:16];
            end
            `SSB_OFF_MULT: begin
                mult_factor_q <= pwdata[`SSB_MULT_FACT_HI:0];
                half_divider_q <= pwdata[`SSB_MULT_HALF];
                line_period_q <= pwdata[`SSB_MULT_PER_HI:`SSB_MULT_PER_LO];
            end
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// current scaling: gain lookup and per-colour fine scaling

reg [14:0] gain_d;

// gain held as hundredths, so the table stays exact integers
always @* begin
    case (global_gain_code_q)
        3'h0: gain_d = `SSB_GAIN0;
        3'h1: gain_d = `SSB_GAIN1;
        3'h2: gain_d = `SSB_GAIN2;
        3'h3: gain_d = `SSB_GAIN3;
        3'h4: gain_d = `SSB_GAIN4;
        3'h5: gain_d = `SSB_GAIN5;
        3'h6: gain_d = `SSB_GAIN6;
        default: gain_d = `SSB_GAIN7;
    endcase
end

wire [8:0] red_step = {1'b0, red_fine_code_q} + 9'h001;
wire [8:0] green_step = {1'b0, green_fine_code_q} + 9'h001;
wire [8:0] blue_step = {1'b0, blue_fine_code_q} + 9'h001;

// scale = gain*100*(1+fine); current = current_reference_pin*scale/25600
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        global_current_gain <= 15'h0000;
        red_current_scale <= 24'h000000;
        green_current_scale <= 24'h000000;
        blue_current_scale <= 24'h000000;
    end else begin
        global_current_gain <= gain_d;
        red_current_scale <= {9'h000, gain_d} * {15'h0000, red_step};
        green_current_scale <= {9'h000, gain_d} * {15'h0000, green_step};
        blue_current_scale <= {9'h000, gain_d} * {15'h0000, blue_step};
    end
end

////////////////////////////////////////////////////////////////////////////////
// serial link: sampled by pclk, rising edge shifts and passes the chain on

ssb_sync #(
    .WIDTH(2)
) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({serial_input, serial_clock}),
    .sync_out(sync_bits)
);

assign sclk_s = sync_bits[0];
assign sin_s = sync_bits[1];
assign sclk_rise = sclk_s & ~sclk_prev_q;

// the bit taken on one rising edge leaves SHIFT_WIDTH edges later, 32 stages of chain
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sclk_prev_q <= 1'b0;
        shift_q <= {SHIFT_WIDTH{1'b0}};
        serial_output <= 1'b0;
    end else begin
        sclk_prev_q <= sclk_s;
        if (sclk_rise) begin
            shift_q <= {shift_q[SHIFT_WIDTH-2:0], sin_s};
            serial_output <= shift_q[SHIFT_WIDTH-1];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// gray clock: each serial edge releases factor ticks, halved by the divider

wire [3:0] fact_eff = (mult_factor_q == 4'h0) ? 4'h1 : mult_factor_q;
wire [3:0] fact_half = (fact_eff[3:1] == 3'h0) ? 4'h1 : {1'b0, fact_eff[3:1]};
wire [3:0] gray_load = half_divider_q ? fact_half : fact_eff;

// ticks model the multiplied clock at pclk granularity; a new serial edge
// restarts the burst, so the rate never outruns the link clock times factor
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        gray_pending_q <= 4'h0;
        gray_tick <= 1'b0;
    end else begin
        gray_tick <= (gray_pending_q != 4'h0);
        if (sclk_rise) begin
            gray_pending_q <= gray_load;
        end else if (gray_pending_q != 4'h0) begin
            gray_pending_q <= gray_pending_q - 4'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// scan sequencing

wire [5:0] lines_max = stack_size_select_q ? `SSB_LINES_STACK : `SSB_LINES_DEV;
wire [5:0] lines_clip = (lines_used_q > lines_max) ? lines_max : lines_used_q;
wire [5:0] lines_lim = (lines_clip == 6'h00) ? 6'h01 : lines_clip;
wire [5:0] pos_next = {1'b0, scan_pos_q} + 6'h01;
wire line_step = scan_enable_q & gray_tick & (tick_cnt_q >= line_period_q);

// unused lines are simply never reached: the position wraps at the limit
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        scan_pos_q <= 5'h00;
        tick_cnt_q <= 12'h000;
    end else if (!scan_enable_q) begin
        scan_pos_q <= 5'h00;
        tick_cnt_q <= 12'h000;
    end else if (gray_tick) begin
        if (line_step) begin
            tick_cnt_q <= 12'h000;
            if (pos_next >= lines_lim) begin
                scan_pos_q <= 5'h00;
            end else begin
                scan_pos_q <= pos_next[4:0];
            end
        end else begin
            tick_cnt_q <= tick_cnt_q + 12'h001;
        end
    end
end

reg drive_d;
reg [3:0] local_line_d;

// second device owns positions 16..31, optionally walked downward
always @* begin
    drive_d = 1'b0;
    local_line_d = scan_pos_q[3:0];
    if (!stack_size_select_q) begin
        drive_d = scan_enable_q;
    end else if (!second_position_q) begin
        drive_d = scan_enable_q & ~scan_pos_q[4];
    end else begin
        drive_d = scan_enable_q & scan_pos_q[4];
        if (second_device_scan_reverse_q) begin
            local_line_d = 4'hF - scan_pos_q[3:0];
        end
    end
end

// one-hot switch drive, all off while this device is idle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        line_switch <= {LINE_COUNT{1'b0}};
    end else begin
        line_switch <= {LINE_COUNT{1'b0}};
        if (drive_d) begin
            line_switch[local_line_d] <= 1'b1;
        end
    end
end

// sections held: bit0 A, bit1 B, bit2 C, bit3 D
wire [3:0] sections = !stack_size_select_q ? 4'h1 :
                      (second_position_q ? 4'hA : 4'h5);

////////////////////////////////////////////////////////////////////////////////
// read data captured in the setup cycle so it is a flop during access

reg [31:0] rd_d;

always @* begin
    case (paddr)
        `SSB_OFF_CTRL: rd_d = {22'h000000, lines_used_q, scan_enable_q,
                               second_position_q, second_device_scan_reverse_q,
                               stack_size_select_q};
        `SSB_OFF_GAIN: rd_d = {29'h00000000, global_gain_code_q};
        `SSB_OFF_FINE: rd_d = {8'h00, blue_fine_code_q, green_fine_code_q,
                               red_fine_code_q};
        `SSB_OFF_MULT: rd_d = {12'h000, line_period_q, 3'h0, half_divider_q,
                               mult_factor_q};
        `SSB_OFF_STAT: rd_d = {1'b0, global_current_gain, 2'h0, sections,
                               drive_d, local_line_d, scan_pos_q};
        `SSB_OFF_RSCL: rd_d = {8'h00, red_current_scale};
        `SSB_OFF_GSCL: rd_d = {8'h00, green_current_scale};
        `SSB_OFF_BSCL: rd_d = {8'h00, blue_current_scale};
        `SSB_OFF_SHFT: rd_d = shift_q[31:0];
        default: rd_d = 32'h00000000;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (setup_phase) begin
        prdata <= pwrite ? 32'h00000000 : rd_d;
    end
end

endmodule
`default_nettype wire

// file: ssb_properties.sv
// checker: gain, scale, link and scan output relations of ssb_top
// assumes binding to ssb_top; watches its ports only
`include "ssb_consts.vh"
`default_nettype none
module ssb_properties #(
    parameter LINE_COUNT = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic serial_clock,
    input wire logic serial_output,
    input wire logic gray_tick,
    input wire logic [LINE_COUNT-1:0] line_switch,
    input wire logic [14:0] global_current_gain,
    input wire logic [23:0] red_current_scale
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] idle_q;
    ////////////////////////////////////////////////////////////////
    // cycles since link clock last seen high, saturating
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) idle_q <= 5'h00;
        else if (serial_clock) idle_q <= 5'h00;
        else if (idle_q != 5'h1F) idle_q <= idle_q + 5'h01;
    end
    sequence s_clk_held;
        $past(serial_clock, 2) && $past(serial_clock);
    endsequence
    property p_gain_table;
        presetn |=> global_current_gain inside {`SSB_GAIN0, `SSB_GAIN1, `SSB_GAIN2,
            `SSB_GAIN3, `SSB_GAIN4, `SSB_GAIN5, `SSB_GAIN6, `SSB_GAIN7};
    endproperty
    a_gain_table: assert property (p_gain_table) else $error("gain off table");
    property p_gain_default;
        $rose(presetn) |=> global_current_gain == 15'h21D5;
    endproperty
    a_gain_default: assert property (p_gain_default) else $error("gain default");
    property p_scale_default;
        $rose(presetn) |=> red_current_scale == 24'h10EA80;
    endproperty
    a_scale_default: assert property (p_scale_default) else $error("scale default");
    // scale must be a whole multiple of the gain once both settle
    property p_scale_ratio;
        global_current_gain != 0 && $stable(global_current_gain) && $stable(red_current_scale)
            |-> red_current_scale % global_current_gain == 0;
    endproperty
    a_scale_ratio: assert property (p_scale_ratio) else $error("scale ratio");
    property p_one_line;
        $onehot0(line_switch);
    endproperty
    a_one_line: assert property (p_one_line) else $error("two lines on");
    property p_serial_output_on_rise;
        $changed(serial_output) |-> s_clk_held;
    endproperty
    a_serial_output_on_rise: assert property (p_serial_output_on_rise) else $error("serial_output moved");
    property p_tick_from_link;
        gray_tick |-> idle_q < 5'h14;
    endproperty
    a_tick_from_link: assert property (p_tick_from_link) else $error("free tick");
    property p_line_on_tick;
        $changed(line_switch) |-> $past(gray_tick) || $past(gray_tick, 2) ||
            $past(gray_tick, 3) || $past(pwrite && penable) || $past(pwrite && penable, 2);
    endproperty
    a_line_on_tick: assert property (p_line_on_tick) else $error("line moved");
endmodule
bind ssb_top ssb_properties #(.LINE_COUNT(LINE_COUNT)) u_props (.pclk, .presetn, .penable,
    .pwrite, .serial_clock, .serial_output, .gray_tick, .line_switch, .global_current_gain,
    .red_current_scale);
`default_nettype wire

// file: ssb_link_model.sv
// model: display controller driving the serial link, msb first
// assumes the block samples the link with its own faster clock
`default_nettype none
module ssb_link_model (
    output logic serial_clock,
    output logic serial_input,
    input wire logic serial_output
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] cap = 64'h0;
    initial begin
        serial_clock = 1'b0;
        serial_input = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // top n bits of w; clock stands low between frames
    task send(input logic [31:0] w, input int n);
        #7;
        for (int i = 0; i < n; i++) begin
            serial_input = w[31-i];
            #200;
            serial_clock = 1'b1;
            cap = {cap[62:0], serial_output};
            #200;
            serial_clock = 1'b0;
        end
        serial_input = ~serial_input; // stale data must not look valid
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// testbench: registers, gain table, ticks, scan order and link of ssb_top
// assumes the link model for the far side and a 20 MHz pclk
`include "ssb_consts.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, last_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, r;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, serial_clock, serial_input, serial_output, gray_tick;
    wire logic [15:0] line_switch;
    wire logic [14:0] global_current_gain;
    wire logic [23:0] red_current_scale, green_current_scale, blue_current_scale;
    int errors = 0, checks_done = 0, ticks = 0, t0;
    logic [14:0] gtab [0:7] = '{`SSB_GAIN0, `SSB_GAIN1, `SSB_GAIN2, `SSB_GAIN3,
        `SSB_GAIN4, `SSB_GAIN5, `SSB_GAIN6, `SSB_GAIN7};
    ssb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .serial_clock, .serial_input, .serial_output, .line_switch,
        .gray_tick, .global_current_gain, .red_current_scale, .green_current_scale,
        .blue_current_scale);
    ssb_link_model u_ctrl (.serial_clock, .serial_input, .serial_output);
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) if (gray_tick === 1'b1) ticks++;
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits for pready, only the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // per tick setting: burst length, then scan position and line drive
    task automatic run_mode(input logic [31:0] ctrl, input int lines, input logic [3:0] sect);
        logic [31:0] cfg [0:3] = '{32'h06, 32'h16, 32'h01, 32'h00};
        int nt [0:3] = '{6, 3, 1, 1};
        int q;
        logic [31:0] e;
        apb(1'b1, `SSB_OFF_CTRL, 32'h0);
        apb(1'b1, `SSB_OFF_CTRL, ctrl);
        q = 0;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `SSB_OFF_MULT, cfg[k]);
            t0 = ticks;
            u_ctrl.send(32'hA5C30F96, 5);
            repeat (12) @(posedge pclk);
            chk(ticks - t0, 5 * nt[k]);
            q = (q + 5 * nt[k]) % lines;
            apb(1'b0, `SSB_OFF_STAT, 32'h0);
            chk(r[4:0], q);
            chk(r[13:10], sect);
            // expected switch from the rule position: own half only, reversed if asked
            e = !ctrl[0] ? 1 << q : (ctrl[2] != (q >= 16)) ? 0 :
                (ctrl[2] & ctrl[1]) ? 16'h8000 >> (q - 16) : 1 << (q % 16);
            chk(line_switch, e);
        end
    endtask
    task test_done;
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog, far beyond the expected run of about 0.1 ms
    initial begin
        #1000000;
        errors++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SSB_OFF_CTRL, 32'h100);
        rd(`SSB_OFF_GAIN, 32'h3);
        rd(`SSB_OFF_FINE, 32'h7F7F7F);
        rd(`SSB_OFF_MULT, 32'h2D14);
        chk(global_current_gain, 15'h21D5);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `SSB_OFF_GAIN, i);
            apb(1'b0, `SSB_OFF_STAT, 32'h0);
            chk(r[30:16], gtab[i]);
            chk(global_current_gain, gtab[i]);
        end
        apb(1'b1, `SSB_OFF_FINE, 32'h007FFF00);
        apb(1'b1, `SSB_OFF_RSCL, 32'h0);
        rd(`SSB_OFF_RSCL, gtab[7]);
        rd(`SSB_OFF_GSCL, gtab[7] * 256);
        chk(blue_current_scale, gtab[7] * 128);
        apb(1'b0, 8'h24, 32'h0);
        chk(r, 32'h0);
        chk(last_err, 1'b1);
        u_ctrl.send(32'h12345678, 32);
        u_ctrl.send(32'h9ABCDEF0, 32);
        repeat (8) @(posedge pclk);
        rd(`SSB_OFF_SHFT, 32'h9ABCDEF0);
        u_ctrl.send(32'h80000000, 1);
        chk(u_ctrl.cap[31:0], 32'h12345678);
        run_mode(32'h20F, 32, 4'hA);
        run_mode(32'h209, 32, 4'h5);
        run_mode(32'h1EF, 30, 4'hA);
        run_mode(32'h1ED, 30, 4'hA);
        run_mode(32'h108, 16, 4'h1);
        run_mode(32'h0E8, 14, 4'h1);
        test_done;
    end
endmodule
`default_nettype wire
